/* rtl/fwhrc_regs.vh */
`ifndef FWHRC_REGS_VH
`define FWHRC_REGS_VH
// opcodes
`define FWHRC_OP_UDPD       8'h79
`define FWHRC_OP_SWRST      8'hF0
`define FWHRC_OP_CONFIRM    8'hD0
`define FWHRC_OP_WRSTAT2    8'h31
`define FWHRC_OP_WREN       8'h06
`define FWHRC_OP_WRDI       8'h04
// reset-enable bit position in the second status byte
`define FWHRC_RESET_ENABLE_BIT_POS      0
// wake pulse in ns, wake-up and reset abort times in us, clock period in ns
`define FWHRC_CLK_NS        4
`define FWHRC_WAKE_PULSE_NS 20
`define FWHRC_WAKE_UP_US    70
`define FWHRC_RST_ABORT_US  60
// counts derived from the times above
`define FWHRC_WAKE_PULSE_CYC ((`FWHRC_WAKE_PULSE_NS + `FWHRC_CLK_NS - 1) / `FWHRC_CLK_NS)
`define FWHRC_WAKE_UP_CYC    ((`FWHRC_WAKE_UP_US * 1000) / `FWHRC_CLK_NS)
`define FWHRC_RST_ABORT_CYC  ((`FWHRC_RST_ABORT_US * 1000) / `FWHRC_CLK_NS)
`endif

/* rtl/fwhrc_sync.v */
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for a group of pin inputs
module fwhrc_sync #(
  parameter W    = 1,
  parameter INIT = 1'b0
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta[i] <= INIT;
          q[i]    <= INIT;
        end else begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate
endmodule // fwhrc_sync
`default_nettype wire

/* rtl/fwhrc_ctrl.v */
`timescale 1ns/1ns
`default_nettype none
`include "fwhrc_regs.vh"

// Overview of operation
// - short cs pulse wakes from ultra-deep power-down; standby after wake-up time
// - bytes shifted during the wake pulse are ignored; pulse still wakes
// - a frame started before wake-up time elapses is ignored entirely
// - cs held low: cs fall wakes; a bit taken before wake-up time elapses drops the command
// - power cycle (reset) leaves power-down with all state at defaults
// - pause never stalls a running program or erase cycle
// - pause entered only with cs low, at a clock-low phase
// - pause lasts while pause pin and cs both asserted
// - while paused output is off, data and clock ignored, protect pin live
// - pause ends at a clock-low phase after the pin releases
// - cs release while paused aborts the frame and clears write-enable latch
// - software reset aborts program or erase, ignores write-enable latch
// - software reset only acts when the reset-enable bit is set
// - reset frame is f0 then d0, later bytes ignored
// - after reset frame, program ends within the reset abort time
// - reset keeps config and reset-enable, clears write-enable latch
// - no reset on short frame or release off a byte boundary
// - opcode 79 frame enters ultra-deep power-down unless busy_in is high; commands then ignored
// - device is back in standby within the wake-up time
module fwhrc_ctrl #(
  parameter WAKE_UP_CYC   = `FWHRC_WAKE_UP_CYC,
  parameter RST_ABORT_CYC = `FWHRC_RST_ABORT_CYC
) (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       cs_n,
  input  wire       sck,
  input  wire       si,
  input  wire       hold_n,
  input  wire       wp_n,
  input  wire       busy_in,
  output reg        so,
  output reg        so_oe,
  output reg        abort_op,
  output reg        write_enable_latch,
  output reg        reset_enable_bit,
  output reg        write_protect,
  output reg        paused,
  output reg        ultra_deep_pd,
  output reg        standby,
  output reg  [7:0] cmd_byte,
  output reg        cmd_valid
);

  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  reg        rst_meta;
  reg        rst_s_n;
  wire [4:0] pins_s;
  wire       cs_s_n;
  wire       sck_s;
  wire       si_s;
  wire       hold_s_n;
  wire       wp_s_n;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_s_n  <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_s_n  <= rst_meta;
    end
  end

  fwhrc_sync #(.W(5), .INIT(1'b1)) u_sync (
    .clk   (mclk),
    .rst_n (rst_s_n),
    .d     ({cs_n, sck, si, hold_n, wp_n}),
    .q     (pins_s)
  );
  assign cs_s_n   = pins_s[4];
  assign sck_s    = pins_s[3];
  assign si_s     = pins_s[2];
  assign hold_s_n = pins_s[1];
  assign wp_s_n   = pins_s[0];

  // ------------------------------------------------------------
  // edge detection and pause tracking
  // ------------------------------------------------------------
  reg  sck_d;
  reg  cs_d_n;
  wire sck_rise = sck_s & ~sck_d;
  wire cs_fall  = ~cs_s_n & cs_d_n;
  wire cs_rise  = cs_s_n & ~cs_d_n;
  reg  paused_on_release;

  always @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      // matches the synchroniser's reset level, so no false sck edge
      sck_d  <= 1'b1;
      cs_d_n <= 1'b1;
      paused <= 1'b0;
    end else begin
      sck_d  <= sck_s;
      cs_d_n <= cs_s_n;
      if (cs_s_n)
        paused <= 1'b0;
      else if (!sck_s)
        paused <= ~hold_s_n;
    end
  end

  // ------------------------------------------------------------
  // frame shifter and bit counter
  // ------------------------------------------------------------
  localparam ST_IDLE  = 4'b0001;
  localparam ST_OPC   = 4'b0010;
  localparam ST_CONF  = 4'b0100;
  localparam ST_SKIP  = 4'b1000;

  reg  [3:0]  fstate;
  reg  [2:0]  bit_cnt;
  reg  [7:0]  shreg;
  reg  [7:0]  opcode;
  reg         rst_armed;
  reg         frame_ignored;
  reg         frame_bits;
  reg         byte_two;
  wire [7:0]  byte_now = {shreg[6:0], si_s};
  wire        bit_take = ~cs_s_n & sck_rise & ~paused;
  wire        byte_done = bit_take & (bit_cnt == 3'd7);

  always @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      fstate     <= ST_IDLE;
      bit_cnt    <= 3'd0;
      shreg      <= 8'h00;
      opcode     <= 8'h00;
      rst_armed  <= 1'b0;
      frame_bits <= 1'b0;
      byte_two   <= 1'b0;
      cmd_byte   <= 8'h00;
      cmd_valid  <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (cs_fall) begin
        fstate     <= ST_OPC;
        bit_cnt    <= 3'd0;
        rst_armed  <= 1'b0;
        frame_bits <= 1'b0;
        byte_two   <= 1'b0;
      end else if (bit_take) begin
        frame_bits <= 1'b1;
        bit_cnt    <= bit_cnt + 3'd1;
        shreg      <= byte_now;
        if (byte_done) begin
          case (fstate)
            ST_OPC: begin
              opcode <= byte_now;
              if (!frame_ignored && !ultra_deep_pd) begin
                cmd_byte  <= byte_now;
                cmd_valid <= 1'b1;
              end
              fstate <= (byte_now == `FWHRC_OP_SWRST || byte_now == `FWHRC_OP_WRSTAT2) ? ST_CONF : ST_SKIP;
            end
            ST_CONF: begin
              byte_two <= 1'b1;
              if (opcode == `FWHRC_OP_SWRST)
                rst_armed <= (byte_now == `FWHRC_OP_CONFIRM);
              fstate <= ST_SKIP;               // later bytes ignored
            end
            ST_SKIP: fstate <= ST_SKIP;
            default: fstate <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // power-down and wake timing
  // ------------------------------------------------------------
  reg  [15:0] wake_cnt;
  reg         waking;
  reg         wake_frame;
  wire        aligned    = (bit_cnt == 3'd0);
  wire        valid_end  = cs_rise & aligned & frame_bits & ~frame_ignored & ~ultra_deep_pd & ~paused_on_release;
  wire        pd_enter   = valid_end & (opcode == `FWHRC_OP_UDPD) & ~busy_in;
  wire        pd_leave   = ultra_deep_pd & cs_fall;
  // a wake frame that was ignored or carried no bits restarts the timer at cs release
  wire        wake_renew = cs_rise & wake_frame & (frame_ignored | ~frame_bits);
  // reset needs both bytes, a byte-aligned end and the enable bit
  wire        sw_reset   = valid_end & (opcode == `FWHRC_OP_SWRST) & rst_armed & byte_two & reset_enable_bit;

  always @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ultra_deep_pd     <= 1'b0;
      standby           <= 1'b1;
      waking            <= 1'b0;
      wake_frame        <= 1'b0;
      wake_cnt          <= 16'h0000;
      frame_ignored     <= 1'b0;
      paused_on_release <= 1'b0;
    end else begin
      paused_on_release <= paused;
      standby           <= ~ultra_deep_pd & ~waking;
      // timer runs regardless of cs so standby returns in time
      if (waking) begin
        if (wake_cnt == 16'h0000)
          waking <= 1'b0;
        else
          wake_cnt <= wake_cnt - 16'h0001;
      end
      if (pd_enter) begin
        ultra_deep_pd <= 1'b1;
        standby       <= 1'b0;
      end
      if (pd_leave) begin
        // timed from cs fall so that the cs-low method can wait it out
        ultra_deep_pd <= 1'b0;
        waking        <= 1'b1;
        wake_cnt      <= WAKE_UP_CYC[15:0];
        wake_frame    <= 1'b1;
        frame_ignored <= 1'b0;
      end else if (cs_fall) begin
        frame_ignored <= waking;
      end else if (bit_take && waking) begin
        // a bit taken while the wake timer runs drops the whole frame
        frame_ignored <= 1'b1;
      end
      if (cs_rise)
        wake_frame <= 1'b0;
      if (wake_renew) begin
        waking   <= 1'b1;
        wake_cnt <= WAKE_UP_CYC[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // status latches
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      write_enable_latch <= 1'b0;
      reset_enable_bit   <= 1'b0;
    end else if (cs_rise && paused_on_release) begin
      // cs release while paused drops the frame
      write_enable_latch <= 1'b0;
    end else if (valid_end) begin
      case (opcode)
        `FWHRC_OP_WREN:  write_enable_latch <= 1'b1;
        `FWHRC_OP_WRDI:  write_enable_latch <= 1'b0;
        `FWHRC_OP_WRSTAT2:
          if (byte_two)
            reset_enable_bit <= shreg[`FWHRC_RESET_ENABLE_BIT_POS];
        `FWHRC_OP_SWRST:
          if (sw_reset)
            write_enable_latch <= 1'b0;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // software reset abort; ends program or erase, busy or not
  // ------------------------------------------------------------
  reg  [15:0] abort_cnt;

  // the affected page is left in an undefined state
  always @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      abort_op  <= 1'b0;
      abort_cnt <= 16'h0000;
    end else if (sw_reset) begin
      abort_op  <= 1'b1;
      abort_cnt <= RST_ABORT_CYC[15:0];
    end else if (abort_cnt != 16'h0000) begin
      abort_cnt <= abort_cnt - 16'h0001;
      if (abort_cnt == 16'h0001)
        abort_op <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // output pin and write protect; program cycles run on unpaused
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      so            <= 1'b0;
      so_oe         <= 1'b0;
      write_protect <= 1'b0;
    end else begin
      write_protect <= ~wp_s_n;
      so            <= 1'b0;
      so_oe         <= 1'b0;
    end
  end

endmodule // fwhrc_ctrl
`default_nettype wire

/* sim/fwhrc_ctrl_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module fwhrc_ctrl_properties #(
  parameter WAKE_UP_CYC   = 17500,
  parameter RST_ABORT_CYC = 15000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic wp_n,
  input wire logic so_oe,
  input wire logic abort_op,
  input wire logic write_enable_latch,
  input wire logic reset_enable_bit,
  input wire logic write_protect,
  input wire logic paused,
  input wire logic ultra_deep_pd,
  input wire logic standby,
  input wire logic cmd_valid
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  so_off_a: assert property (!so_oe) else $error("output enable raised");
  wp_live_a: assert property ($fell(wp_n) |-> ##[1:5] write_protect) else $error("protect lost");
  pause_end_a: assert property ($rose(cs_n) |-> ##[1:6] !paused) else $error("pause kept");
  pause_cs_a: assert property (cs_n && $past(cs_n, 6) |-> !paused) else $error("pause unselected");
  cmd_sb_a: assert property (cmd_valid |-> standby) else $error("command outside standby");
  pd_sb_a: assert property (ultra_deep_pd |-> !standby) else $error("standby in power-down");
  reset_enable_bit_gate_a: assert property (abort_op |-> reset_enable_bit) else $error("abort without enable");
  wel_clear_a: assert property ($rose(abort_op) |-> ##[0:1] !write_enable_latch) else $error("latch kept");
  abort_len_a: assert property ($rose(abort_op) |-> abort_op[*8]) else $error("abort too short");
  abort_cs_a: assert property ($rose(abort_op) |-> cs_n) else $error("abort inside frame");
  cover property ($rose(abort_op));
  cover property ($rose(paused));
  cover property ($fell(ultra_deep_pd));
endmodule // fwhrc_ctrl_properties
`default_nettype wire

/* sim/fwhrc_host.sv */
`timescale 1ns/1ns
`default_nettype none
module fwhrc_host (
  input  wire logic mclk,
  output var logic  cs_n,
  output var logic  sck,
  output var logic  si,
  output var logic  hold_n
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic sel(input logic v);
    w(4);
    cs_n = v;
    if (v)
      si = ~si; // released line must not show the last bit
    w(8);
  endtask
  // clock idles low between frames
  task automatic bits(input logic [23:0] d, input int n);
    for (int i = 23; i > 23 - n; i--) begin
      si = d[i];
      w(4);
      sck = 1'b1;
      w(4);
      sck = 1'b0;
    end
  endtask
  task automatic frame(input logic [23:0] d, input int n);
    sel(1'b0);
    bits(d, n);
    sel(1'b1);
  endtask
  // holds sck at one level, to place a pause change in a clock phase
  task automatic clk_lvl(input logic v);
    sck = v;
    w(8);
  endtask
  // takes effect at the next clock-low phase
  task automatic pause(input logic v);
    hold_n = v;
    w(8);
  endtask
  task automatic settle();
    w(80);
  endtask
endmodule // fwhrc_host
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wp_n = 1'b1;
  logic       busy_in = 1'b0;
  wire        cs_n, sck, si, hold_n, so, so_oe, abort_op, paused, standby, cmd_valid;
  wire        write_enable_latch, reset_enable_bit, write_protect, ultra_deep_pd;
  wire  [7:0] cmd_byte;
  logic [7:0] last = 8'h00;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         n_cmd = 0;
  int         c;
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (cmd_valid === 1'b1) begin
    n_cmd++;
    last <= cmd_byte;
  end
  fwhrc_host i_fwhrc_host (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
  fwhrc_ctrl #(.WAKE_UP_CYC(60), .RST_ABORT_CYC(20)) i_fwhrc_ctrl (
    .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .busy_in(busy_in), .so(so), .so_oe(so_oe), .abort_op(abort_op), .write_enable_latch(write_enable_latch),
    .reset_enable_bit(reset_enable_bit), .write_protect(write_protect), .paused(paused),
    .ultra_deep_pd(ultra_deep_pd), .standby(standby), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic fr(input logic [23:0] d, input int n);
    i_fwhrc_host.frame(d, n);
  endtask
  task automatic t_power();
    rst_n = 1'b0;
    w(4);
    rst_n = 1'b1;
    w(8);
    chk({so, so_oe, abort_op, write_enable_latch, reset_enable_bit, paused, ultra_deep_pd, standby}, 8'h01);
  endtask
  task automatic t_swrst();
    fr(24'h060000, 8);
    chk(last, 8'h06);
    fr(24'hF0D000, 16);
    chk(8'(abort_op), 8'h00);
    fr(24'h310100, 16);
    chk(8'(reset_enable_bit), 8'h01);
    fr(24'hF0D000, 20);
    fr(24'hF00000, 8);
    fr(24'hF0AA00, 16);
    chk({6'h00, abort_op, write_enable_latch}, 8'h01);
    fr(24'hF0D0FF, 24);
    chk({5'h00, abort_op, write_enable_latch, reset_enable_bit}, 8'h05);
    w(30);
    chk(8'(abort_op), 8'h00);
  endtask
  task automatic t_hold();
    i_fwhrc_host.sel(1'b0);
    i_fwhrc_host.bits(24'h000000, 4);
    i_fwhrc_host.pause(1'b0);
    chk(8'(paused), 8'h01);
    wp_n = 1'b0;
    i_fwhrc_host.bits(24'hFFFFFF, 4);
    chk({6'h00, write_protect, so_oe}, 8'h02);
    wp_n = 1'b1;
    i_fwhrc_host.pause(1'b1);
    chk(8'(paused), 8'h00);
    i_fwhrc_host.bits(24'h600000, 4);
    i_fwhrc_host.sel(1'b1);
    chk(8'(write_enable_latch), 8'h01);
    i_fwhrc_host.sel(1'b0);
    i_fwhrc_host.clk_lvl(1'b1);
    i_fwhrc_host.pause(1'b0);
    chk(8'(paused), 8'h00);
    i_fwhrc_host.clk_lvl(1'b0);
    chk(8'(paused), 8'h01);
    i_fwhrc_host.sel(1'b1);
    chk({6'h00, paused, write_enable_latch}, 8'h00);
    i_fwhrc_host.pause(1'b1);
  endtask
  task automatic t_udpd();
    busy_in = 1'b1;
    fr(24'h790000, 8);
    chk(8'(ultra_deep_pd), 8'h00);
    busy_in = 1'b0;
    fr(24'h790000, 8);
    chk({6'h00, ultra_deep_pd, standby}, 8'h02);
    c = n_cmd;
    fr(24'h060000, 8);
    chk(8'(standby), 8'h00);
    fr(24'h060000, 8);
    i_fwhrc_host.settle();
    chk({standby, ultra_deep_pd, write_enable_latch, 5'h00}, 8'h80);
    fr(24'h790000, 8);
    i_fwhrc_host.sel(1'b0);
    i_fwhrc_host.bits(24'h060000, 8);
    i_fwhrc_host.sel(1'b1);
    i_fwhrc_host.settle();
    chk({standby, ultra_deep_pd, write_enable_latch, 5'h00}, 8'h80);
    chk(8'(n_cmd - c), 8'h01);
    fr(24'h060000, 8);
    chk(8'(write_enable_latch), 8'h01);
    fr(24'h790000, 8);
    i_fwhrc_host.sel(1'b0);
    i_fwhrc_host.settle();
    i_fwhrc_host.bits(24'h040000, 8);
    i_fwhrc_host.sel(1'b1);
    chk({standby, write_enable_latch, 6'h00}, 8'h80);
    fr(24'h790000, 8);
    chk(8'(ultra_deep_pd), 8'h01);
  endtask
  initial begin
    t_power();
    t_swrst();
    t_hold();
    t_udpd();
    t_power();
    conclude();
  end
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule // tb_top
bind fwhrc_ctrl fwhrc_ctrl_properties #(
  .WAKE_UP_CYC(WAKE_UP_CYC),
  .RST_ABORT_CYC(RST_ABORT_CYC)
) i_fwhrc_ctrl_properties (
  .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .wp_n(wp_n), .so_oe(so_oe), .abort_op(abort_op),
  .write_enable_latch(write_enable_latch), .reset_enable_bit(reset_enable_bit),
  .write_protect(write_protect), .paused(paused), .ultra_deep_pd(ultra_deep_pd), .standby(standby),
  .cmd_valid(cmd_valid)
);
`default_nettype wire
